// File: cie_consts.vh
// constants for the instruction execute block: opcodes, register offsets, fields, resets
`ifndef CIE_CONSTS_VH
`define CIE_CONSTS_VH

// ----------------------------------------------------------------
// instruction words (10 bits)
// ----------------------------------------------------------------
`define CIE_OP_NOP        10'h000
`define CIE_OP_ADD_MEM    10'h00A
`define CIE_OP_ADD_MEM_C  10'h00B
`define CIE_OP_ADD_IMM    10'h060
`define CIE_OP_IMM_MASK   10'h3F0
`define CIE_OP_CONV_START 10'h29F
`define CIE_OP_WDT_STOP   10'h29C
`define CIE_OP_SEL_CERAM  10'h29A
`define CIE_OP_SEL_RC     10'h29B
`define CIE_OP_MODE_TO_A  10'h252
`define CIE_OP_A_TO_MODE  10'h2B6

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CIE_REG_INSTR     8'h00
`define CIE_REG_ACC       8'h04
`define CIE_REG_CARRY     8'h08
`define CIE_REG_DPTR      8'h0C
`define CIE_REG_RAMDATA   8'h10
`define CIE_REG_CONVCTRL  8'h14
`define CIE_REG_MODE      8'h18
`define CIE_REG_PC        8'h1C
`define CIE_REG_FLAGS     8'h20
`define CIE_REG_INTSTAT   8'h24
`define CIE_REG_INTMASK   8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CIE_CONV_MODE_BIT 3
`define CIE_FLG_DONE      0
`define CIE_FLG_SKIP      1
`define CIE_FLG_WDT_ARM   2
`define CIE_FLG_CLK_RC    3
`define CIE_EV_CONV       0
`define CIE_EV_COMP       1
`define CIE_EV_DONE       2
`define CIE_EV_SKIP       3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIE_RST_NIB       4'h0
`define CIE_RST_PC        8'h00
`define CIE_RST_INSTR     10'h000
`define CIE_RST_WORD      32'h0000_0000

`endif

// File: cie_execute.v
// instruction execute core with ahb-lite register access
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cie_consts.vh"

// Overview of operation
// - add-immediate adds low four opcode bits to accumulator, result back in accumulator.
// - add-immediate never changes the carry flag.
// - add-immediate skips the next instruction when no overflow, else runs it.
// - conversion start clears done flag; with mode bit 0 starts a conversion.
// - with mode bit 1 conversion start clears done flag and starts comparator.
// - the mode bit is bit 3 of the converter control register.
// - add-memory adds ram nibble at data pointer to accumulator; carry unchanged.
// - add-memory-with-carry adds accumulator, ram nibble, carry; carry gets carry out.
// - no-operation only advances the program counter by one.
// - watchdog-stop-enable arms halting the watchdog; watchdog runs until stop done.
// - ceramic select switches system clock source to ceramic resonator.
// - rc select switches system clock source to rc oscillator.
module cie_execute
(
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        convDone,
    output wire        convStart,
    output wire        compStart,
    output wire        wdtStopArm,
    output wire        clkSelRc,
    output wire        irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [31:0] hrdata_q;
    reg         hreadyout_q;
    reg         hresp_q;
    reg         wrPend_q;
    reg         rdPend_q;
    reg  [7:0]  addr_q;
    reg  [9:0]  instr_q;
    reg  [3:0]  acc_q;
    reg         carry_q;
    reg  [3:0]  dptr_q;
    wire [63:0] ramFlat;
    reg  [3:0]  convCtrl_q;
    reg  [3:0]  mode_q;
    reg  [7:0]  pc_q;
    reg         doneFlag_q;
    reg         skip_q;
    reg         wdtArm_q;
    reg         clkRc_q;
    reg  [3:0]  intStat_q;
    reg  [3:0]  intMask_q;
    reg         convStart_q;
    reg         compStart_q;
    reg         irq_q;

    reg  [3:0]  acc_d;
    reg         carry_d;
    reg  [3:0]  mode_d;
    reg         skip_d;
    reg         wdtArm_d;
    reg         clkRc_d;
    reg         convGo;
    reg         compGo;
    reg         doneClr;
    reg  [4:0]  sum;
    reg  [31:0] rdMux;

    wire        addrTaken = hsel & hready & htrans[1];
    wire        wrNow     = wrPend_q;
    wire [9:0]  wrInstr   = hwdata[9:0];
    wire        execNow   = wrNow & (addr_q == `CIE_REG_INSTR);
    wire [3:0]  ramNib    = ramFlat[{dptr_q, 2'b00} +: 4];
    wire [3:0]  evNow;

    assign hrdata     = hrdata_q;
    assign hreadyout  = hreadyout_q;
    assign hresp      = hresp_q;
    assign convStart  = convStart_q;
    assign compStart  = compStart_q;
    assign wdtStopArm = wdtArm_q;
    assign clkSelRc   = clkRc_q;
    assign irq        = irq_q;

    // ----------------------------------------------------------------
    // instruction decode and execute
    // ----------------------------------------------------------------
    always @*
    begin
        acc_d    = acc_q;
        carry_d  = carry_q;
        mode_d   = mode_q;
        skip_d   = skip_q;
        wdtArm_d = wdtArm_q;
        clkRc_d  = clkRc_q;
        convGo   = 1'b0;
        compGo   = 1'b0;
        doneClr  = 1'b0;
        sum      = 5'h00;
        if (execNow)
        begin
            skip_d = 1'b0;
            if (!skip_q)
            begin
                if ((wrInstr & `CIE_OP_IMM_MASK) == `CIE_OP_ADD_IMM)
                begin
                    sum    = {1'b0, acc_q} + {1'b0, wrInstr[3:0]};
                    acc_d  = sum[3:0];
                    skip_d = ~sum[4];
                end
                else
                begin
                    case (wrInstr)
                        `CIE_OP_ADD_MEM:
                        begin
                            sum   = {1'b0, acc_q} + {1'b0, ramNib};
                            acc_d = sum[3:0];
                        end
                        `CIE_OP_ADD_MEM_C:
                        begin
                            sum     = {1'b0, acc_q} + {1'b0, ramNib} + {4'h0, carry_q};
                            acc_d   = sum[3:0];
                            carry_d = sum[4];
                        end
                        `CIE_OP_CONV_START:
                        begin
                            doneClr = 1'b1;
                            convGo  = ~convCtrl_q[`CIE_CONV_MODE_BIT];
                            compGo  = convCtrl_q[`CIE_CONV_MODE_BIT];
                        end
                        `CIE_OP_WDT_STOP:   wdtArm_d = 1'b1;
                        `CIE_OP_SEL_CERAM:  clkRc_d  = 1'b0;
                        `CIE_OP_SEL_RC:     clkRc_d  = 1'b1;
                        `CIE_OP_MODE_TO_A:  acc_d    = mode_q;
                        `CIE_OP_A_TO_MODE:  mode_d   = acc_q;
                        default:            acc_d    = acc_q;
                    endcase
                end
            end
        end
    end

    assign evNow = {execNow & skip_d, convDone, compGo, convGo};

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always @*
    begin
        rdMux = `CIE_RST_WORD;
        case (addr_q)
            `CIE_REG_INSTR:    rdMux = {22'h00_0000, instr_q};
            `CIE_REG_ACC:      rdMux = {28'h000_0000, acc_q};
            `CIE_REG_CARRY:    rdMux = {31'h0000_0000, carry_q};
            `CIE_REG_DPTR:     rdMux = {28'h000_0000, dptr_q};
            `CIE_REG_RAMDATA:  rdMux = {28'h000_0000, ramNib};
            `CIE_REG_CONVCTRL: rdMux = {28'h000_0000, convCtrl_q};
            `CIE_REG_MODE:     rdMux = {28'h000_0000, mode_q};
            `CIE_REG_PC:       rdMux = {24'h00_0000, pc_q};
            `CIE_REG_FLAGS:    rdMux = {28'h000_0000, clkRc_q, wdtArm_q, skip_q, doneFlag_q};
            `CIE_REG_INTSTAT:  rdMux = {28'h000_0000, intStat_q};
            `CIE_REG_INTMASK:  rdMux = {28'h000_0000, intMask_q};
            default:           rdMux = `CIE_RST_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // bus slave: writes zero-wait, reads one wait state
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hrdata_q    <= `CIE_RST_WORD;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            wrPend_q    <= 1'b0;
            rdPend_q    <= 1'b0;
            addr_q      <= 8'h00;
        end
        else
        begin
            hresp_q <= 1'b0;
            if (rdPend_q)
            begin
                hrdata_q    <= rdMux;
                hreadyout_q <= 1'b1;
                rdPend_q    <= 1'b0;
                wrPend_q    <= 1'b0;
            end
            else
            begin
                wrPend_q <= addrTaken & hwrite;
                rdPend_q <= addrTaken & ~hwrite;
                if (addrTaken)
                begin
                    addr_q      <= {haddr[7:2], 2'b00};
                    hreadyout_q <= hwrite;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // core registers
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            instr_q     <= `CIE_RST_INSTR;
            acc_q       <= `CIE_RST_NIB;
            carry_q     <= 1'b0;
            dptr_q      <= `CIE_RST_NIB;
            convCtrl_q  <= `CIE_RST_NIB;
            mode_q      <= `CIE_RST_NIB;
            pc_q        <= `CIE_RST_PC;
            doneFlag_q  <= 1'b0;
            skip_q      <= 1'b0;
            wdtArm_q    <= 1'b0;
            clkRc_q     <= 1'b0;
            intStat_q   <= `CIE_RST_NIB;
            intMask_q   <= `CIE_RST_NIB;
            convStart_q <= 1'b0;
            compStart_q <= 1'b0;
            irq_q       <= 1'b0;
        end
        else
        begin
            acc_q       <= acc_d;
            carry_q     <= carry_d;
            mode_q      <= mode_d;
            skip_q      <= skip_d;
            wdtArm_q    <= wdtArm_d;
            clkRc_q     <= clkRc_d;
            convStart_q <= convGo;
            compStart_q <= compGo;
            if (execNow)
            begin
                instr_q <= wrInstr;
                pc_q    <= pc_q + 8'h01;
            end
            // completion from the converter wins over the clearing start
            if (convDone)
                doneFlag_q <= 1'b1;
            else if (doneClr)
                doneFlag_q <= 1'b0;
            if (wrNow)
            begin
                case (addr_q)
                    `CIE_REG_ACC:      acc_q      <= hwdata[3:0];
                    `CIE_REG_CARRY:    carry_q    <= hwdata[0];
                    `CIE_REG_DPTR:     dptr_q     <= hwdata[3:0];
                    `CIE_REG_CONVCTRL: convCtrl_q <= hwdata[3:0];
                    `CIE_REG_MODE:     mode_q     <= hwdata[3:0];
                    `CIE_REG_INTMASK:  intMask_q  <= hwdata[3:0];
                    default:           dptr_q     <= dptr_q;
                endcase
            end
            // new events win over a write-one clear
            if (wrNow && addr_q == `CIE_REG_INTSTAT)
                intStat_q <= (intStat_q & ~hwdata[3:0]) | evNow;
            else
                intStat_q <= intStat_q | evNow;
            irq_q <= |((intStat_q | evNow) & intMask_q &
                       ~((wrNow && addr_q == `CIE_REG_INTSTAT) ? hwdata[3:0] & ~evNow : 4'h0));
        end
    end

    // ----------------------------------------------------------------
    // data ram, one nibble per entry
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : gRam
            // each entry owns its flip-flops so the storage has one driver per nibble
            reg [3:0] nib_q;
            always @(posedge sys_clk)
            begin
                if (!rst_n)
                    nib_q <= `CIE_RST_NIB;
                else if (wrNow && addr_q == `CIE_REG_RAMDATA && dptr_q == gi)
                    nib_q <= hwdata[3:0];
            end
            assign ramFlat[gi*4 +: 4] = nib_q;
        end
    endgenerate

endmodule // cie_execute

// File: cie_execute_chk.sv
// bound checker for the instruction execute block ports
`timescale 1ns/1ps
`include "cie_consts.vh"

module cie_execute_chk
(
    input wire        sys_clk,
    input wire        rst_n,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire        convStart,
    input wire        compStart,
    input wire        wdtStopArm
);
    logic       pend_q;
    logic [9:0] word_q;
    wire        taken  = hsel && hready && htrans[1];
    wire        convEx = (word_q == `CIE_OP_CONV_START);

    // word_q holds the instruction word executed at the previous edge, else a no-op
    always @(posedge sys_clk)
    begin
        pend_q <= rst_n && (hready ? (taken && hwrite && haddr[7:2] == 6'h00) : pend_q);
        word_q <= (rst_n && pend_q && hready) ? hwdata[9:0] : `CIE_OP_NOP;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence oneWait;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_read_wait: assert property (taken && !hwrite |=> oneWait)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write data phase stretched");
    chk_wait_cause: assert property (!hreadyout |-> $past(taken) && !$past(hwrite))
        else $error("wait state without read");
    chk_resp_okay: assert property (!hresp) else $error("error response");
    chk_pulse_excl: assert property (!(convStart && compStart))
        else $error("both start pulses");
    chk_conv_cause: assert property (convStart |-> convEx || $past(convEx))
        else $error("stray conversion start");
    chk_comp_cause: assert property (compStart |-> convEx || $past(convEx))
        else $error("stray comparator start");
    chk_wdt_sticky: assert property (wdtStopArm |=> wdtStopArm)
        else $error("watchdog stop arm dropped");
endmodule // cie_execute_chk

bind cie_execute cie_execute_chk u_chk
(
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .convStart(convStart), .compStart(compStart), .wdtStopArm(wdtStopArm)
);

// File: tb_top.sv
// self-checking bench for the instruction execute block
`timescale 1ns/1ps
`include "cie_consts.vh"

module tb_top;
    logic        sys_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        hsel       = 1'b1;
    logic [31:0] haddr      = 32'h0000_0000;
    logic [1:0]  htrans     = 2'b00;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0000_0000;
    logic        convDone   = 1'b0;
    logic [31:0] rdVal;
    logic [7:0]  pcExp      = 8'h00;
    int          errTotal   = 0;
    int          checksDone = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, convStart, compStart, wdtStopArm, clkSelRc, irq;

    cie_execute uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .convDone(convDone),
        .convStart(convStart), .compStart(compStart), .wdtStopArm(wdtStopArm),
        .clkSelRc(clkSelRc), .irq(irq)
    );

    always #12.5 sys_clk = ~sys_clk;

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdVal = hrdata;
    endtask
    task automatic exec(input logic [9:0] w);
        bus(1'b1, `CIE_REG_INSTR, {22'h00_0000, w});
        pcExp++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        cmp32(rdVal, exp);
    endtask

    task automatic t_add_imm;
        bus(1'b1, `CIE_REG_ACC, 32'h9);
        bus(1'b1, `CIE_REG_CARRY, 32'h1);
        exec(`CIE_OP_ADD_IMM | 10'h003);
        exec(`CIE_OP_ADD_IMM | 10'h005);
        exec(`CIE_OP_ADD_IMM | 10'h00F);
        exec(`CIE_OP_ADD_IMM | 10'h002);
        exec(`CIE_OP_ADD_IMM | 10'h001);
        rd(`CIE_REG_ACC, 32'hD);
        rd(`CIE_REG_CARRY, 32'h1);
    endtask
    task automatic t_add_mem;
        bus(1'b1, `CIE_REG_DPTR, 32'h5);
        bus(1'b1, `CIE_REG_RAMDATA, 32'hE);
        bus(1'b1, `CIE_REG_CARRY, 32'h0);
        exec(`CIE_OP_ADD_MEM);
        rd(`CIE_REG_ACC, 32'hB);
        rd(`CIE_REG_CARRY, 32'h0);
        exec(`CIE_OP_ADD_MEM_C);
        exec(`CIE_OP_ADD_MEM_C);
        rd(`CIE_REG_ACC, 32'h8);
        rd(`CIE_REG_CARRY, 32'h1);
    endtask
    task automatic t_conv;
        convDone <= 1'b1;
        @(posedge sys_clk);
        convDone <= 1'b0;
        exec(`CIE_OP_CONV_START);
        @(posedge sys_clk);
        cmp1(convStart, 1'b1);
        cmp1(compStart, 1'b0);
        bus(1'b1, `CIE_REG_CONVCTRL, 32'h8);
        exec(`CIE_OP_CONV_START);
        @(posedge sys_clk);
        cmp1(compStart, 1'b1);
        cmp1(convStart, 1'b0);
        rd(`CIE_REG_INTSTAT, 32'hF);
        cmp1(irq, 1'b0);
        bus(1'b1, `CIE_REG_INTMASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        cmp1(irq, 1'b1);
        bus(1'b1, `CIE_REG_INTSTAT, 32'h2);
        repeat (2) @(posedge sys_clk);
        cmp1(irq, 1'b0);
    endtask
    task automatic t_misc;
        exec(`CIE_OP_WDT_STOP);
        exec(`CIE_OP_SEL_RC);
        rd(`CIE_REG_FLAGS, 32'hC);
        cmp1(wdtStopArm, 1'b1);
        cmp1(clkSelRc, 1'b1);
        exec(`CIE_OP_SEL_CERAM);
        exec(`CIE_OP_NOP);
        cmp1(clkSelRc, 1'b0);
        bus(1'b1, `CIE_REG_ACC, 32'h6);
        exec(`CIE_OP_A_TO_MODE);
        bus(1'b1, `CIE_REG_ACC, 32'h3);
        exec(`CIE_OP_MODE_TO_A);
        rd(`CIE_REG_ACC, 32'h6);
        hsel <= 1'b0;
        bus(1'b1, `CIE_REG_ACC, 32'h9);
        hsel <= 1'b1;
        rd(`CIE_REG_ACC, 32'h6);
        rd(`CIE_REG_INSTR, {22'h00_0000, `CIE_OP_MODE_TO_A});
        bus(1'b1, `CIE_REG_PC, 32'h55);
        rd(`CIE_REG_PC, {24'h00_0000, pcExp});
        rd(8'h3C, 32'h0);
    endtask

    task automatic give_verdict;
        if (errTotal == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_add_imm();
        t_add_mem();
        t_conv();
        t_misc();
        give_verdict();
    end

    initial
    begin
        #20000;
        errTotal++;
        give_verdict();
    end
endmodule // tb_top
